// ### verilog/rff_defs.vh
// constants for the event flag byte and frequency readout
`ifndef RFF_DEFS_VH
`define RFF_DEFS_VH
`define RFF_ADDR_W          7
`define RFF_OFS_EVENT_FLAGS 7'h06
`define RFF_OFS_FREQ_UPPER  7'h07
`define RFF_RST_EVENT_FLAGS 8'h3F
`define RFF_RST_FREQ_UPPER  8'h00
`define RFF_BIT_MODE_CHG    7
`define RFF_BIT_REF_LOSS    6
`define RFF_BIT_STANDBY_CHG 0
`define RFF_FREQ_MSB        18
`define RFF_FREQ_LSB        16
`define RFF_FREQ_W          19
`define RFF_MISS_LIMIT      2'h2
`define RFF_MODE_W          3
`define RFF_MODE_FREERUN    3'h1
`define RFF_MODE_HOLDOVER   3'h2
`endif

// ### verilog/rff_miss_counter.v
// counts missing reference cycles for the main loop
`timescale 1ns/100ps
`include "rff_defs.vh"
module rff_miss_counter (
	// clock and reset
	input  wire       clock_in,
	input  wire       rst_n_in,
	// reference activity
	input  wire       ref_edge_in,
	input  wire       cycle_due_in,
	input  wire       inhibit_in,
	// result
	output reg        loss_out
);
	reg [1:0] miss_ff;
	reg [1:0] nxt_miss;

	always @* begin
		nxt_miss = miss_ff;
		if (inhibit_in || ref_edge_in)
			nxt_miss = 2'h0;
		else if (cycle_due_in && miss_ff != `RFF_MISS_LIMIT)
			nxt_miss = miss_ff + 2'h1;
	end

	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			miss_ff  <= 2'h0;
			loss_out <= 1'b0;
		end else begin
			miss_ff  <= nxt_miss;
			// one-cycle pulse when the second miss lands
			loss_out <= !inhibit_in && !ref_edge_in && cycle_due_in
				&& (miss_ff == `RFF_MISS_LIMIT - 2'h1);
		end
	end
endmodule // rff_miss_counter

// ### verilog/rff_flag_bank.v
// event flag byte and upper frequency readout registers
`timescale 1ns/100ps
`include "rff_defs.vh"
// How it works
// - flag main loop reference loss after two missing input cycles.
// - never raise reference loss flag in free-run or holdover.
// - bit 6 latches on loss, cleared by writing 1.
// - bit 0 sets on any standby input validity change.
// - bit 0 stays latched until software writes 1.
// - frequency byte bits 2:0 show loop frequency bits 18:16.
// - selector 0 reports main loop frequency.
// - bit 7 latches on operating mode change, write 1 clears.
module rff_flag_bank (
	// clock and reset
	input  wire                    clock_in,
	input  wire                    rst_n_in,
	// register port
	input  wire [`RFF_ADDR_W-1:0]  reg_addr_in,
	input  wire                    reg_wr_in,
	input  wire [7:0]              reg_wdata_in,
	output reg  [7:0]              reg_rdata_out,
	// main loop status
	input  wire [`RFF_MODE_W-1:0]  main_loop_mode_in,
	input  wire                    main_ref_edge_in,
	input  wire                    main_cycle_due_in,
	// standby input
	input  wire                    standby_clock_input_valid_in,
	// frequency sources and selector
	input  wire [`RFF_FREQ_W-1:0]  main_loop_freq_in,
	input  wire [`RFF_FREQ_W-1:0]  auxiliary_loop_freq_in,
	input  wire                    loop_readout_selector_in,
	// flag outputs
	output reg                     main_loop_fast_ref_loss_flag_out,
	output reg                     standby_input_change_flag_out,
	output reg                     mode_change_flag_out
);
	reg [7:0]             flags_ff;
	wire [7:0]            nxt_flags;
	wire [7:0]            flag_set;
	wire [7:0]            flag_clr;
	reg [2:0]             freq_ff;
	reg [`RFF_MODE_W-1:0] mode_ff;
	reg                   standby_ff;
	reg                   valid_seen_ff;
	wire                  loss_pulse;
	wire                  inhibit;
	wire                  clr_wr;
	wire [7:0]            rd_mux;
	genvar                gi;

	// offset decode shared by the clear strobe and the read mux
	function rff_at_offset;
		input [`RFF_ADDR_W-1:0] addr;
		input [`RFF_ADDR_W-1:0] ofs;
		begin
			rff_at_offset = (addr == ofs);
		end
	endfunction

	assign inhibit = (main_loop_mode_in == `RFF_MODE_FREERUN) ||
		(main_loop_mode_in == `RFF_MODE_HOLDOVER);

	rff_miss_counter u_miss (
		.clock_in     (clock_in),
		.rst_n_in     (rst_n_in),
		.ref_edge_in  (main_ref_edge_in),
		.cycle_due_in (main_cycle_due_in),
		.inhibit_in   (inhibit),
		.loss_out     (loss_pulse)
	);

	assign clr_wr = reg_wr_in && rff_at_offset(reg_addr_in, `RFF_OFS_EVENT_FLAGS);

	// hardware events per bit; unused bits never set again after a clear
	assign flag_set[`RFF_BIT_MODE_CHG]    = valid_seen_ff && (main_loop_mode_in != mode_ff);
	assign flag_set[`RFF_BIT_REF_LOSS]    = loss_pulse && !inhibit;
	assign flag_set[5:1]                  = 5'h00;
	assign flag_set[`RFF_BIT_STANDBY_CHG] = valid_seen_ff && (standby_clock_input_valid_in != standby_ff);

	assign flag_clr = clr_wr ? reg_wdata_in : 8'h00;

	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
			// set beats clear so an event in the clearing cycle survives
			assign nxt_flags[gi] = flag_set[gi] | (flags_ff[gi] & ~flag_clr[gi]);
		end
	endgenerate

	assign rd_mux = rff_at_offset(reg_addr_in, `RFF_OFS_EVENT_FLAGS) ? nxt_flags :
		rff_at_offset(reg_addr_in, `RFF_OFS_FREQ_UPPER) ? {5'h00, freq_ff} : 8'h00;

	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flags_ff      <= `RFF_RST_EVENT_FLAGS;
			freq_ff       <= 3'h0;
			mode_ff       <= {`RFF_MODE_W{1'b0}};
			standby_ff    <= 1'b0;
			valid_seen_ff <= 1'b0;
			reg_rdata_out <= 8'h00;
			main_loop_fast_ref_loss_flag_out <= 1'b0;
			standby_input_change_flag_out    <= 1'b0;
			mode_change_flag_out             <= 1'b0;
		end else begin
			flags_ff      <= nxt_flags;
			// sampled history only valid after first post-reset edge
			valid_seen_ff <= 1'b1;
			mode_ff       <= main_loop_mode_in;
			standby_ff    <= standby_clock_input_valid_in;
			if (loop_readout_selector_in)
				freq_ff <= auxiliary_loop_freq_in[`RFF_FREQ_MSB:`RFF_FREQ_LSB];
			else
				freq_ff <= main_loop_freq_in[`RFF_FREQ_MSB:`RFF_FREQ_LSB];
			reg_rdata_out <= rd_mux;
			main_loop_fast_ref_loss_flag_out <= nxt_flags[`RFF_BIT_REF_LOSS];
			standby_input_change_flag_out    <= nxt_flags[`RFF_BIT_STANDBY_CHG];
			mode_change_flag_out             <= nxt_flags[`RFF_BIT_MODE_CHG];
		end
	end
endmodule // rff_flag_bank

// ### tb/rff_flag_bank_assertions.sv
// checker for the event flag byte
`timescale 1ns/100ps
module rff_flag_bank_chk(input logic clock_in,rst_n_in,reg_wr_in,main_cycle_due_in,main_ref_edge_in,
	standby_clock_input_valid_in,loop_readout_selector_in,main_loop_fast_ref_loss_flag_out,
	standby_input_change_flag_out,mode_change_flag_out,input logic [6:0] reg_addr_in,
	input logic [7:0] reg_wdata_in,reg_rdata_out,input logic [2:0] main_loop_mode_in,
	input logic [18:0] main_loop_freq_in,auxiliary_loop_freq_in);
	wire w=reg_wr_in&&reg_addr_in==7'h06;
	wire run=main_loop_mode_in!=3'h1&&main_loop_mode_in!=3'h2;
	wire miss=main_cycle_due_in&&!main_ref_edge_in&&run;
	wire rd=reg_addr_in==7'h07;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	freq_main_a: assert property(rd&&!loop_readout_selector_in&&$stable({loop_readout_selector_in,main_loop_freq_in})
		|=> reg_rdata_out=={5'h00,$past(main_loop_freq_in[18:16])}) else $error("bad main freq");
	freq_aux_a: assert property(rd&&loop_readout_selector_in&&$stable({loop_readout_selector_in,auxiliary_loop_freq_in})
		|=> reg_rdata_out=={5'h00,$past(auxiliary_loop_freq_in[18:16])}) else $error("bad aux freq");
	loss_set_a: assert property(miss ##1 miss |-> ##[1:2] main_loop_fast_ref_loss_flag_out) else $error("no loss");
	loss_block_a: assert property($rose(main_loop_fast_ref_loss_flag_out) |-> $past(run)||$past(run,2)) else $error("loss in hold");
	loss_hold_a: assert property($fell(main_loop_fast_ref_loss_flag_out) |-> $past(w&&reg_wdata_in[6])||$past(w&&reg_wdata_in[6],2)) else $error("loss lost");
	sb_set_a: assert property($changed(standby_clock_input_valid_in) |-> ##[1:3] standby_input_change_flag_out) else $error("no sb");
	sb_hold_a: assert property($fell(standby_input_change_flag_out) |-> $past(w&&reg_wdata_in[0])||$past(w&&reg_wdata_in[0],2)) else $error("sb lost");
	mode_set_a: assert property($changed(main_loop_mode_in) |-> ##[1:3] mode_change_flag_out) else $error("no mode flag");
	cover property(miss ##1 miss);
	cover property(w&&reg_wdata_in[0]);
	cover property(rd&&loop_readout_selector_in);
endmodule // rff_flag_bank_chk
bind rff_flag_bank rff_flag_bank_chk i_chk(.*);

// ### tb/rff_flag_bank_tb.sv
// bench for the event flag byte
`timescale 1ns/100ps
module rff_flag_bank_tb;
	logic clock_in=0,rst_n_in=0,reg_wr_in=0,main_ref_edge_in=0,main_cycle_due_in=0,standby_clock_input_valid_in=0;
	logic loop_readout_selector_in=0,main_loop_fast_ref_loss_flag_out,standby_input_change_flag_out,mode_change_flag_out;
	logic [6:0] reg_addr_in=0;
	logic [7:0] reg_wdata_in=0,reg_rdata_out;
	logic [2:0] main_loop_mode_in=0;
	logic [18:0] main_loop_freq_in=19'h50000,auxiliary_loop_freq_in=19'h7FFFF;
	int error_cnt=0,tests_run=0;
	rff_flag_bank i_rff_flag_bank(.*);
	initial forever #2.5 clock_in=~clock_in;
	task cyc(int n=1); repeat(n) @(posedge clock_in); #1; endtask
	task wr(logic [6:0] a,logic [7:0] d); reg_addr_in=a; reg_wdata_in=d; reg_wr_in=1; cyc(); reg_wr_in=0; endtask
	task rd(logic [6:0] a,logic [7:0] e); reg_addr_in=a; cyc(); tests_run++;
		if(reg_rdata_out!==e) begin error_cnt++; $display("wrong value %0t: %h %h",$time,reg_rdata_out,e); end
	endtask
	task due(logic d,logic r); main_cycle_due_in=d; main_ref_edge_in=r; cyc(); main_cycle_due_in=0; main_ref_edge_in=0; cyc(); endtask
	task miss2; main_cycle_due_in=1; cyc(2); main_cycle_due_in=0; endtask
	task summarize; if(error_cnt==0&&tests_run>0) $display("Test passed"); else $display("Test failed"); $finish; endtask
	initial begin #100000; error_cnt++; summarize; end
	initial begin
		cyc(12); rst_n_in=1;
		rd(7'h06,8'h3F);
		rd(7'h07,8'h05);
		wr(7'h06,8'hFF); rd(7'h06,8'h00);
		due(1,0); due(0,1); due(1,0); rd(7'h06,8'h00);
		miss2; rd(7'h06,8'h40);
		wr(7'h06,8'h40); rd(7'h06,8'h00);
		for(int m=1;m<3;m++) begin main_loop_mode_in=m; miss2; rd(7'h06,8'h80); end
		main_loop_mode_in=0; cyc(2); wr(7'h06,8'h80); rd(7'h06,8'h00);
		standby_clock_input_valid_in=1; rd(7'h06,8'h01);
		standby_clock_input_valid_in=0; cyc(2); wr(7'h06,8'h01); rd(7'h06,8'h00);
		standby_clock_input_valid_in=1; rd(7'h06,8'h01);
		loop_readout_selector_in=1; cyc(); rd(7'h07,8'h07);
		wr(7'h07,8'h00); rd(7'h07,8'h07); rd(7'h10,8'h00);
		summarize;
	end
endmodule // rff_flag_bank_tb
